/* hw/csm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the mode and I/O block
// Functional notes
// R01 - Four loop modes: off, fixed, variable, torque
// R02 - Mode change taken only while no move
// R03 - Loop off: open loop, fixed run/hold
// R04 - Loop on: compare encoder with commanded steps
// R05 - Lead/lag register; make-up corrects position
// R06 - Fixed loop mode uses run/hold current
// R07 - Variable mode scales current, run is ceiling
// R08 - Torque mode: torque percent, speed limited
// R09 - Profile torque forces torque mode
// R10 - Loop off keeps stall detection with encoder
// R11 - Inputs take general function codes
// R12 - Codes 13/14/15 make step, encoder, up/down
// R13 - Active level per input and output
// R14 - Input flags and 4-bit input word
// R15 - Analog voltage or current range select
// R16 - Analog read returns raw 12-bit counts
// R17 - Trip on any selected event combination
// R18 - Output function trip or alternates
// R19 - Trip state set by event or host
// R20 - Inputs synchronised before level and decode
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

// ==========================================================================
// Byte offsets of the 32-bit registers on the Wishbone bus
`define CSM_OFS_CTRL      8'h00
`define CSM_OFS_CURRENT   8'h04
`define CSM_OFS_TORQUE    8'h08
`define CSM_OFS_INCFG     8'h0c
`define CSM_OFS_ANCFG     8'h10
`define CSM_OFS_OUTCFG    8'h14
`define CSM_OFS_STATUS    8'h18
`define CSM_OFS_LEADLAG   8'h1c
`define CSM_OFS_ANALOG    8'h20
`define CSM_OFS_OUTWRITE  8'h24

// ==========================================================================
// Field positions
`define CSM_CTRL_MODE_LSB 0
`define CSM_CTRL_MAKEUP   2
`define CSM_CTRL_PROFTRQ  3
`define CSM_CTRL_BOUND_LSB 8
`define CSM_CUR_HOLD_LSB  8
`define CSM_TRQ_SPEED_LSB 8
`define CSM_INCFG_STRIDE  8
`define CSM_OUT_ACTIVE    5
`define CSM_OUT_MASK_LSB  8
`define CSM_AN_PARAM      4

// ==========================================================================
// Reset values
`define CSM_RST_CTRL      32'h0000_0800
`define CSM_RST_CURRENT   32'h0000_1950
`define CSM_RST_TORQUE    32'h0000_0a32
`define CSM_RST_INCFG     32'h0000_2020
`define CSM_RST_INCFG_B   8'h20
`define CSM_RST_ANCFG     32'h0000_0009
`define CSM_RST_OUTCFG    32'h0000_003c

// ==========================================================================
// Function codes
`define CSM_FN_GP         5'h00
`define CSM_FN_HOME       5'h01
`define CSM_FN_LIMP       5'h02
`define CSM_FN_LIMN       5'h03
`define CSM_FN_START      5'h04
`define CSM_FN_SSTOP      5'h05
`define CSM_FN_PAUSE      5'h06
`define CSM_FN_JOGP       5'h07
`define CSM_FN_JOGN       5'h08
`define CSM_FN_AVOLT      5'h09
`define CSM_FN_ACURR      5'h0a
`define CSM_FN_RESET      5'h0b
`define CSM_FN_STEPDIR    5'h0d
`define CSM_FN_QUAD       5'h0e
`define CSM_FN_UPDN       5'h0f
`define CSM_FN_OUT_GP     5'h10
`define CSM_FN_MOVING     5'h11
`define CSM_FN_SWERR      5'h12
`define CSM_FN_VELCHG     5'h14
`define CSM_FN_LOCKED     5'h15
`define CSM_FN_POSCHG     5'h17
`define CSM_FN_LOOPACT    5'h18
`define CSM_FN_MAKEUPACT  5'h19
`define CSM_FN_TRIP       5'h1c

// ==========================================================================
// Timing
`define CSM_CLK_HZ        25000000
`define CSM_TICK_US       1
`define CSM_TICK_CYC      ((`CSM_CLK_HZ / 1000000) * `CSM_TICK_US)
`define CSM_MAKEUP_US     100
`define CSM_MAKEUP_TICKS  (`CSM_MAKEUP_US / `CSM_TICK_US)
`define CSM_VAR_GAIN      2

`endif

/* hw/csm_pkg.sv */
// Types shared by the mode and I/O block
package csm_pkg;

  // ==========================================================================
  // Loop operating mode
  typedef enum logic [1:0] {
    CSM_LOOP_OFF,
    CSM_LOOP_FIXED,
    CSM_LOOP_VAR,
    CSM_LOOP_TORQUE
  } csm_mode_t;

  // Per input setup: function code and active level
  typedef struct packed {
    logic [1:0] spare;
    logic       active;
    logic [4:0] func;
  } csm_in_cfg_t;

  // Decoded input functions, one flag per function
  typedef struct packed {
    logic home;
    logic limit_pos;
    logic limit_neg;
    logic program_start_func;
    logic soft_stop;
    logic pause;
    logic jog_plus;
    logic jog_minus;
    logic soft_reset;
  } csm_in_func_t;

  // Step and direction pair
  typedef struct packed {
    logic step;
    logic dir;
  } csm_step_t;

endpackage

/* hw/csm_sync.sv */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module csm_sync #(
  parameter int W = 1  // Number of bits
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;  // First stage, read only by second stage

  // ==========================================================================
  // Two stages; nothing else looks at the first
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

/* hw/csm_mode_io.sv */
// Closed-loop stepper mode control, opto inputs, analog input and trip output
`timescale 1ns/1ps
`include "csm_regs.svh"
module csm_mode_io #(
  parameter bit HAS_ENCODER = 1'b1  // Variant carries a shaft encoder
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Wishbone slave
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [7:0]            i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [31:0]           i_wb_dat,
  output logic      [31:0]           o_wb_dat,
  output logic                       o_wb_ack,
  // Motion side, same clock
  input  wire csm_pkg::csm_step_t    i_cmd,
  input  wire logic                  i_moving,
  input  wire logic [11:0]           i_adc_data,
  input  wire logic                  i_adc_valid,
  input  wire logic [6:0]            i_trip_events,
  input  wire logic                  i_sw_error,
  input  wire logic                  i_vel_changing,
  input  wire logic                  i_locked_rotor,
  // Pins
  input  wire logic [1:0]            i_enc_ab,
  input  wire logic [2:0]            i_opto,
  // Bridge and I/O outputs
  output csm_pkg::csm_step_t         o_bridge,
  output logic      [7:0]            o_current_pct,
  output csm_pkg::csm_in_func_t      o_in_func,
  output csm_pkg::csm_step_t         o_ext,
  output logic      [1:0]            o_adc_range,
  output logic                       o_stall,
  output logic                       o_trip_pin
);

  // ==========================================================================
  // Registers held by software
  logic [1:0]                 mode_q;       // Requested loop mode
  logic                       makeup_en_q;  // Position make-up enable
  logic                       prof_trq_q;   // Profile torque active
  logic [7:0]                 bound_q;      // Lead/lag control bound
  logic [7:0]                 run_pct_q;    // Run current percent
  logic [7:0]                 hold_pct_q;   // Hold current percent
  logic [7:0]                 trq_pct_q;    // Torque percent
  logic [7:0]                 trq_gap_q;    // Least microseconds between steps
  csm_pkg::csm_in_cfg_t [2:0] in_cfg_q;     // Setup of inputs 2..4
  logic [4:0]                 an_func_q;    // Analog function
  logic                       an_param_q;   // Analog range parameter
  logic [4:0]                 out_func_q;   // Output point 3 function
  logic                       out_act_q;    // Output active level
  logic [6:0]                 trip_mask_q;  // Selected trip events
  logic                       trip_q;       // Trip output logic state
  logic [11:0]                adc_q;        // Last analog conversion

  // Live state
  logic signed [15:0]         leadlag_q;    // Commanded minus actual
  logic [1:0]                 enc_prev_q;   // Previous encoder phases
  logic [2:0]                 in_prev_q;    // Previous logic input levels
  logic [4:0]                 tick_cnt_q;   // Microsecond divider
  logic                       tick_q;       // One-cycle microsecond enable
  logic [7:0]                 mk_cnt_q;     // Ticks to next make-up step
  logic [7:0]                 gap_cnt_q;    // Ticks since last bridge step
  logic                       mk_active_q;  // Make-up move running
  logic                       wb_req;       // Fresh bus request

  // ==========================================================================
  // Encoder and opto pins cross into the clock domain first
  logic [1:0] enc_s;
  logic [2:0] opto_s;
  csm_sync #(.W(2)) u_enc_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_enc_ab),
    .o_sync    (enc_s)
  );
  csm_sync #(.W(3)) u_opto_sync (  // R20
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_opto),
    .o_sync    (opto_s)
  );

  // Quadrature step from phase pair: {valid, dir}
  function automatic logic [1:0] quad(input logic [1:0] p, input logic [1:0] c);
    logic [3:0] t;
    t = {p, c};
    case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b11;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b10;
      default:                            quad = 2'b00;
    endcase
  endfunction

  // ==========================================================================
  // Input logic levels after active-level setting
  logic [2:0] in_lvl;
  logic [3:0] input_word_var;  // Bit 0 unused, bits 3..1 are inputs 2..4
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      assign in_lvl[gi] = in_cfg_q[gi].active ? opto_s[gi] : ~opto_s[gi];  // R13
    end
  endgenerate
  assign input_word_var = {in_lvl, 1'b0};  // R14

  // Function decode, OR of every input holding a code
  csm_pkg::csm_in_func_t fn_d;
  always_comb begin
    fn_d = '0;
    for (int k = 0; k < 3; k++) begin  // R11
      case (in_cfg_q[k].func)
        `CSM_FN_HOME:  fn_d.home               = fn_d.home | in_lvl[k];
        `CSM_FN_LIMP:  fn_d.limit_pos          = fn_d.limit_pos | in_lvl[k];
        `CSM_FN_LIMN:  fn_d.limit_neg          = fn_d.limit_neg | in_lvl[k];
        `CSM_FN_START: fn_d.program_start_func = fn_d.program_start_func | in_lvl[k];
        `CSM_FN_SSTOP: fn_d.soft_stop          = fn_d.soft_stop | in_lvl[k];
        `CSM_FN_PAUSE: fn_d.pause              = fn_d.pause | in_lvl[k];
        `CSM_FN_JOGP:  fn_d.jog_plus           = fn_d.jog_plus | in_lvl[k];
        `CSM_FN_JOGN:  fn_d.jog_minus          = fn_d.jog_minus | in_lvl[k];
        `CSM_FN_RESET: fn_d.soft_reset         = fn_d.soft_reset | in_lvl[k];
        default:       fn_d = fn_d;
      endcase
    end
  end

  // External step source on inputs 3 and 4; code taken from input 3
  csm_pkg::csm_step_t ext_d;
  logic [1:0]         ext_q;
  always_comb begin
    ext_d = '0;
    ext_q = quad({in_prev_q[1], in_prev_q[2]}, {in_lvl[1], in_lvl[2]});
    case (in_cfg_q[1].func)  // R12
      `CSM_FN_STEPDIR: begin
        ext_d.step = in_lvl[1] & ~in_prev_q[1];
        ext_d.dir  = in_lvl[2];
      end
      `CSM_FN_QUAD: begin
        ext_d.step = ext_q[1];
        ext_d.dir  = ext_q[0];
      end
      `CSM_FN_UPDN: begin
        ext_d.step = (in_lvl[1] & ~in_prev_q[1]) | (in_lvl[2] & ~in_prev_q[2]);
        ext_d.dir  = in_lvl[1] & ~in_prev_q[1];
      end
      default: ext_d = '0;
    endcase
  end

  // Input functions and external step registered out
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_in_func <= '0;
      o_ext     <= '0;
      in_prev_q <= '0;
    end else begin
      o_in_func <= fn_d;
      o_ext     <= ext_d;
      in_prev_q <= in_lvl;
    end
  end

  // ==========================================================================
  // Effective mode: profile torque overrides the stored mode
  csm_pkg::csm_mode_t mode_eff;
  logic               loop_on;
  assign mode_eff = prof_trq_q ? csm_pkg::CSM_LOOP_TORQUE
                               : csm_pkg::csm_mode_t'(mode_q);  // R09 R01
  assign loop_on  = (mode_eff != csm_pkg::CSM_LOOP_OFF);

  // Lead/lag magnitude against the control bound
  logic [15:0] ll_abs;
  logic        over_bound;
  assign ll_abs     = leadlag_q[15] ? 16'(-leadlag_q) : 16'(leadlag_q);
  assign over_bound = (bound_q != 8'h00) && (ll_abs >= {8'h00, bound_q});

  // Microsecond divider shared by make-up and torque speed limit
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 5'(`CSM_TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
      tick_q     <= 1'b0;
    end
  end

  // ==========================================================================
  // Bridge step selection per mode
  logic      mk_fire;
  logic      trq_ok;
  csm_pkg::csm_step_t br_d;
  assign mk_fire = loop_on && makeup_en_q && !i_moving && (leadlag_q != 16'sh0000)
                   && tick_q && (mk_cnt_q == 8'h00);  // R05
  assign trq_ok  = (gap_cnt_q >= trq_gap_q);
  always_comb begin
    br_d = '0;
    case (mode_eff)
      csm_pkg::CSM_LOOP_OFF: br_d = i_cmd;  // R03
      csm_pkg::CSM_LOOP_FIXED, csm_pkg::CSM_LOOP_VAR: begin
        // Steps are held back while the lead/lag magnitude is at or past the bound; make-up returns them
        br_d.step = i_cmd.step & ~over_bound;  // R04
        br_d.dir  = i_cmd.dir;
      end
      csm_pkg::CSM_LOOP_TORQUE: begin
        br_d.step = i_cmd.step & ~over_bound & trq_ok;  // R08
        br_d.dir  = i_cmd.dir;
      end
      default: br_d = '0;
    endcase
    if (mk_fire) begin
      br_d.step = 1'b1;
      br_d.dir  = ~leadlag_q[15];
    end
  end

  // Bridge step register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bridge <= '0;
    end else begin
      o_bridge <= br_d;
    end
  end

  // Make-up pacing and activity
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mk_cnt_q    <= '0;
      mk_active_q <= 1'b0;
    end else begin
      mk_active_q <= loop_on && makeup_en_q && !i_moving && (leadlag_q != 16'sh0000);
      if (tick_q) begin
        mk_cnt_q <= (mk_cnt_q == 8'h00) ? 8'(`CSM_MAKEUP_TICKS - 1) : mk_cnt_q - 8'h01;
      end
    end
  end

  // Torque speed limit: ticks since last bridge step, saturating
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      gap_cnt_q <= '0;
    end else if (br_d.step) begin
      gap_cnt_q <= '0;
    end else if (tick_q && gap_cnt_q != 8'hff) begin
      gap_cnt_q <= gap_cnt_q + 8'h01;  // R08
    end
  end

  // Lead/lag: commanded steps add, encoder counts subtract; make-up steps are not counted
  logic [1:0]         enc_q;
  logic signed [15:0] ll_cmd;
  logic signed [15:0] ll_enc;
  assign enc_q  = quad(enc_prev_q, enc_s);
  assign ll_cmd = !i_cmd.step ? 16'sh0000 : (i_cmd.dir ? 16'sh0001 : -16'sh0001);
  assign ll_enc = !enc_q[1] ? 16'sh0000 : (enc_q[0] ? 16'sh0001 : -16'sh0001);
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      leadlag_q  <= '0;
      enc_prev_q <= '0;
    end else begin
      enc_prev_q <= enc_s;
      if (HAS_ENCODER) begin
        // Make-up moves only the rotor; the encoder count then closes the gap
        leadlag_q <= leadlag_q - ll_enc + ll_cmd;  // R05
      end
    end
  end

  // Stall flag while loop off, only with an encoder
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_stall <= 1'b0;
    end else begin
      o_stall <= HAS_ENCODER && !loop_on && over_bound;  // R10
    end
  end

  // ==========================================================================
  // Bridge current per mode
  logic [15:0] var_need;
  logic [7:0]  cur_d;
  assign var_need = {8'h00, hold_pct_q} + 16'(ll_abs * `CSM_VAR_GAIN);
  always_comb begin
    case (mode_eff)
      csm_pkg::CSM_LOOP_OFF,
      csm_pkg::CSM_LOOP_FIXED: cur_d = i_moving ? run_pct_q : hold_pct_q;  // R03 R06
      csm_pkg::CSM_LOOP_VAR: begin
        // Run current is the ceiling
        cur_d = !i_moving ? hold_pct_q
              : (var_need > {8'h00, run_pct_q}) ? run_pct_q : var_need[7:0];  // R07
      end
      csm_pkg::CSM_LOOP_TORQUE: cur_d = trq_pct_q;  // R08
      default:                  cur_d = hold_pct_q;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_current_pct <= '0;
    end else begin
      o_current_pct <= cur_d;
    end
  end

  // ==========================================================================
  // Analog capture and range select
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      adc_q       <= '0;
      o_adc_range <= 2'b00;
    end else begin
      if (i_adc_valid) begin
        adc_q <= i_adc_data;  // R16
      end
      o_adc_range <= {an_func_q == `CSM_FN_ACURR, an_param_q};  // R15
    end
  end

  // ==========================================================================
  // Trip state and output point
  logic wr_outw;
  logic out_val;
  assign wr_outw = wb_req && i_wb_we && (i_wb_adr == `CSM_OFS_OUTWRITE) && i_wb_sel[0];
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      trip_q <= 1'b0;
    end else if (|(i_trip_events & trip_mask_q)) begin
      trip_q <= 1'b1;  // R17 R19
    end else if (wr_outw) begin
      trip_q <= i_wb_dat[0];  // R19
    end
  end
  always_comb begin
    case (out_func_q)  // R18
      `CSM_FN_TRIP, `CSM_FN_OUT_GP: out_val = trip_q;
      `CSM_FN_MOVING:    out_val = i_moving;
      `CSM_FN_SWERR:     out_val = i_sw_error;
      `CSM_FN_VELCHG:    out_val = i_vel_changing;
      `CSM_FN_LOCKED:    out_val = i_locked_rotor;
      `CSM_FN_POSCHG:    out_val = o_bridge.step;
      `CSM_FN_LOOPACT:   out_val = loop_on;
      `CSM_FN_MAKEUPACT: out_val = mk_active_q;
      default:           out_val = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_trip_pin <= 1'b0;
    end else begin
      o_trip_pin <= out_act_q ? out_val : ~out_val;  // R13
    end
  end

  // ==========================================================================
  // Wishbone writes, low byte lanes only where fields sit
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mode_q      <= 2'(`CSM_RST_CTRL);
      makeup_en_q <= 1'b0;
      prof_trq_q  <= 1'b0;
      bound_q     <= 8'(`CSM_RST_CTRL >> `CSM_CTRL_BOUND_LSB);
      run_pct_q   <= 8'(`CSM_RST_CURRENT);
      hold_pct_q  <= 8'(`CSM_RST_CURRENT >> `CSM_CUR_HOLD_LSB);
      trq_pct_q   <= 8'(`CSM_RST_TORQUE);
      trq_gap_q   <= 8'(`CSM_RST_TORQUE >> `CSM_TRQ_SPEED_LSB);
      in_cfg_q    <= {3{`CSM_RST_INCFG_B}};
      an_func_q   <= 5'(`CSM_RST_ANCFG);
      an_param_q  <= 1'b0;
      out_func_q  <= 5'(`CSM_RST_OUTCFG);
      out_act_q   <= 1'b1;
      trip_mask_q <= '0;
    end else if (wb_req && i_wb_we) begin
      case (i_wb_adr)
        `CSM_OFS_CTRL: begin
          if (i_wb_sel[0]) begin
            if (!i_moving) begin
              mode_q <= i_wb_dat[`CSM_CTRL_MODE_LSB +: 2];  // R02
            end
            makeup_en_q <= i_wb_dat[`CSM_CTRL_MAKEUP];
            prof_trq_q  <= i_wb_dat[`CSM_CTRL_PROFTRQ];
          end
          if (i_wb_sel[1]) bound_q <= i_wb_dat[`CSM_CTRL_BOUND_LSB +: 8];
        end
        `CSM_OFS_CURRENT: begin
          if (i_wb_sel[0]) run_pct_q  <= i_wb_dat[7:0];
          if (i_wb_sel[1]) hold_pct_q <= i_wb_dat[`CSM_CUR_HOLD_LSB +: 8];
        end
        `CSM_OFS_TORQUE: begin
          if (i_wb_sel[0]) trq_pct_q <= i_wb_dat[7:0];
          if (i_wb_sel[1]) trq_gap_q <= i_wb_dat[`CSM_TRQ_SPEED_LSB +: 8];
        end
        `CSM_OFS_INCFG: begin
          for (int k = 0; k < 3; k++) begin
            if (i_wb_sel[k]) in_cfg_q[k] <= i_wb_dat[k*`CSM_INCFG_STRIDE +: 8];  // R11 R13
          end
        end
        `CSM_OFS_ANCFG: begin
          if (i_wb_sel[0]) begin
            an_func_q  <= i_wb_dat[3:0] == 4'(`CSM_FN_ACURR) ? `CSM_FN_ACURR : `CSM_FN_AVOLT;
            an_param_q <= i_wb_dat[`CSM_AN_PARAM];
          end
        end
        `CSM_OFS_OUTCFG: begin
          if (i_wb_sel[0]) begin
            out_func_q <= i_wb_dat[4:0];
            out_act_q  <= i_wb_dat[`CSM_OUT_ACTIVE];
          end
          if (i_wb_sel[1]) trip_mask_q <= i_wb_dat[`CSM_OUT_MASK_LSB +: 7];
        end
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Wishbone read mux and single-cycle acknowledge
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    case (i_wb_adr)
      `CSM_OFS_CTRL:     rd_d = {16'h0000, bound_q, 4'h0, prof_trq_q, makeup_en_q, mode_q};
      `CSM_OFS_CURRENT:  rd_d = {16'h0000, hold_pct_q, run_pct_q};
      `CSM_OFS_TORQUE:   rd_d = {16'h0000, trq_gap_q, trq_pct_q};
      `CSM_OFS_INCFG:    rd_d = {8'h00, in_cfg_q};
      `CSM_OFS_ANCFG:    rd_d = {27'h0, an_param_q, 4'(an_func_q)};
      `CSM_OFS_OUTCFG:   rd_d = {17'h0, trip_mask_q, 2'b00, out_act_q, out_func_q};
      `CSM_OFS_STATUS:   rd_d = {19'h0, o_trip_pin, input_word_var, 1'b0, trip_q,
                                 mk_active_q, loop_on, o_stall, i_moving, mode_eff};  // R14
      `CSM_OFS_LEADLAG:  rd_d = {{16{leadlag_q[15]}}, leadlag_q};  // R05
      `CSM_OFS_ANALOG:   rd_d = {20'h0, adc_q};  // R16
      `CSM_OFS_OUTWRITE: rd_d = {31'h0, trip_q};
      default:           rd_d = '0;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= (wb_req && !i_wb_we) ? rd_d : 32'h0000_0000;
    end
  end

endmodule

/* bench/csm_mode_io_props.sv */
// Checker of bus handshake, step pulses and range updates of the mode and I/O block
`timescale 1ns/1ps
module csm_mode_io_props (
  input wire logic               i_clk,
  input wire logic               i_reset_n,
  input wire logic               i_wb_cyc,
  input wire logic               i_wb_stb,
  input wire logic               i_wb_we,
  input wire logic               o_wb_ack,
  input wire logic [31:0]        o_wb_dat,
  input wire csm_pkg::csm_step_t o_bridge,
  input wire csm_pkg::csm_step_t o_ext,
  input wire logic [1:0]         o_adc_range
);
  // ==========================================================
  // One clock domain, reset masks every check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  sequence s_idle; !i_wb_cyc [*2]; endsequence
  a_ack_late: assert property (s_req |=> o_wb_ack) else $error("ack late");
  a_ack_once: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
  a_ack_quiet: assert property (s_idle |-> !o_wb_ack) else $error("ack while idle");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data off ack");
  a_step_pulse: assert property (o_bridge.step |=> !o_bridge.step) else $error("bridge step");
  a_ext_pulse: assert property (o_ext.step |=> !o_ext.step) else $error("ext step");
  // Range only moves after a bus write lands
  a_range_write: assert property ($changed(o_adc_range) |->
    $past(i_wb_we && i_wb_stb, 1) || $past(i_wb_we && i_wb_stb, 2)) else $error("range moved");
endmodule
bind csm_mode_io csm_mode_io_props csm_mode_io_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
  .o_wb_dat(o_wb_dat), .o_bridge(o_bridge), .o_ext(o_ext), .o_adc_range(o_adc_range));

/* bench/csm_bridge_model.sv */
// Bridge and shaft encoder model following the bridge step pulses
`timescale 1ns/1ps
module csm_bridge_model (
  input  wire logic               i_clk,
  input  wire csm_pkg::csm_step_t i_bridge,
  output logic [1:0]              o_enc_ab
);
  logic [1:0] pos_q = 2'h0;  // Electrical position, wraps
  // Rotor follows each step, so the loop sees no lag
  always_ff @(posedge i_clk) begin
    if (i_bridge.step) begin
      pos_q <= i_bridge.dir ? pos_q + 2'h1 : pos_q - 2'h1;
    end
  end
  // Gray phases so only one line moves per step
  assign o_enc_ab = {pos_q[1], pos_q[1] ^ pos_q[0]};
endmodule

/* bench/csm_mode_io_tb_top.sv */
// Self-checking bench of the mode and I/O block
`timescale 1ns/1ps
`include "csm_regs.svh"
module csm_mode_io_tb_top;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, req = 1'b0, we = 1'b0, moving = 1'b0;
  logic        adc_v = 1'b0, ack, stall, trip;
  logic [7:0]  adr = 8'h00, cur;
  logic [31:0] dat = 32'h0, rd, odat;
  logic [6:0]  ev = 7'h00;
  logic [2:0]  opto = 3'h0;
  logic [11:0] adc = 12'h000;
  logic [1:0]  enc, rng;
  csm_pkg::csm_step_t cmd = 2'h0, brg, ext;
  csm_pkg::csm_in_func_t fn;
  int          err_count = 0, checks = 0;
  csm_mode_io csm_mode_io_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat),
    .o_wb_dat(odat), .o_wb_ack(ack), .i_cmd(cmd), .i_moving(moving), .i_adc_data(adc),
    .i_adc_valid(adc_v), .i_trip_events(ev), .i_sw_error(1'b0), .i_vel_changing(1'b0),
    .i_locked_rotor(1'b0), .i_enc_ab(enc), .i_opto(opto), .o_bridge(brg),
    .o_current_pct(cur), .o_in_func(fn), .o_ext(ext), .o_adc_range(rng), .o_stall(stall),
    .o_trip_pin(trip));
  csm_bridge_model csm_bridge_model_inst (.i_clk(i_clk), .i_bridge(brg), .o_enc_ab(enc));
  initial forever #20 i_clk = ~i_clk;
  // ==========================================================
  // Bus cycle, compare and wait helpers
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do @(posedge i_clk) n++; while (ack !== 1'b1 && n < 20);
    rd = odat;
    if (n >= 20) err_count++;
    req <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    wb(1'b0, `CSM_OFS_CTRL, 32'h0);
    chk(rd, `CSM_RST_CTRL);
    wb(1'b1, 8'h30, 32'hffff_ffff);
    wb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `CSM_OFS_OUTCFG, 32'h0);
    chk(rd, `CSM_RST_OUTCFG);
  endtask
  task automatic t_cur;
    chk(cur, 8'h19);
    @(posedge i_clk);
    moving <= 1'b1;
    cmd <= 2'h3;
    @(posedge i_clk);
    cmd <= 2'h0;
    @(negedge i_clk);
    chk(brg, 2'h3);
    settle(3);
    chk(cur, 8'h50);
    chk(stall, 1'b0);
  endtask
  task automatic t_mode;
    wb(1'b1, `CSM_OFS_CTRL, 32'h0000_0801);
    wb(1'b0, `CSM_OFS_STATUS, 32'h0);
    chk(rd[1:0], 2'h0);
    moving <= 1'b0;
    wb(1'b1, `CSM_OFS_CTRL, 32'h0000_0802);
    wb(1'b0, `CSM_OFS_STATUS, 32'h0);
    chk(rd[1:0], 2'h2);
    wb(1'b1, `CSM_OFS_CTRL, 32'h0000_0808);
    wb(1'b0, `CSM_OFS_STATUS, 32'h0);
    chk(rd[4:0], 5'h13);
  endtask
  task automatic t_io;
    wb(1'b1, `CSM_OFS_INCFG, 32'h0020_2d01);
    opto <= 3'h6;
    settle(5);
    chk(fn, 9'h100);
    chk(ext, 2'h1);
    wb(1'b0, `CSM_OFS_STATUS, 32'h0);
    chk(rd[11:10], 2'h3);
    adc <= 12'habc;
    adc_v <= 1'b1;
    @(posedge i_clk);
    adc_v <= 1'b0;
    wb(1'b0, `CSM_OFS_ANALOG, 32'h0);
    chk(rd, 32'habc);
    wb(1'b1, `CSM_OFS_ANCFG, 32'h1a);
    settle(3);
    chk(rng, 2'h3);
  endtask
  task automatic t_trip;
    wb(1'b1, `CSM_OFS_OUTCFG, 32'h083c);
    ev <= 7'h08;
    settle(3);
    chk(trip, 1'b1);
    @(posedge i_clk);
    ev <= 7'h00;
    wb(1'b1, `CSM_OFS_OUTWRITE, 32'h0);
    settle(2);
    chk(trip, 1'b0);
    wb(1'b1, `CSM_OFS_OUTCFG, 32'h081c);
    settle(2);
    chk(trip, 1'b1);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_cur;
    t_mode;
    t_io;
    t_trip;
    give_verdict;
  end
  // Hang guard, far beyond the hundred or so cycles used
  initial begin
    #100us;
    err_count++;
    give_verdict;
  end
endmodule
